/* common/rps_params.svh */
/*
  Constants of the remappable pin select block: register word indices,
  field positions, reset codes and sizes.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

// Sizes
`define RPS_NUM_PINS   26
`define RPS_NUM_IN     8
`define RPS_NUM_OUT    6
`define RPS_SEL_W      5
`define RPS_REG_W      16
`define RPS_DATA_W     32
`define RPS_ADDR_W     4
`define RPS_BE_W       4

// Selector fields inside a 16-bit register
`define RPS_HI_MSB     12
`define RPS_HI_LSB     8
`define RPS_LO_MSB     4
`define RPS_LO_LSB     0
`define RPS_HI_BYTE    1
`define RPS_LO_BYTE    0

// Codes
`define RPS_IN_SEL_RST  5'h1f
`define RPS_OUT_SEL_RST 5'h00
`define RPS_MAX_PIN     5'h19
`define RPS_FUNC_NONE   5'h00

// Register word indices, byte address is four times the index
`define RPS_IDX_CAPTURE 4'h0
`define RPS_IDX_FAULT   4'h1
`define RPS_IDX_UART    4'h2
`define RPS_IDX_SPI     4'h3
`define RPS_IDX_SPI_SS  4'h4
`define RPS_IDX_OUT01   4'h5
`define RPS_IDX_OUT23   4'h6
`define RPS_IDX_OUT45   4'h7

// Input selector slots
`define RPS_IN_CAP8    0
`define RPS_IN_CAP7    1
`define RPS_IN_FAULT   2
`define RPS_IN_CTS     3
`define RPS_IN_RX      4
`define RPS_IN_SCK     5
`define RPS_IN_SDI     6
`define RPS_IN_SS      7

`endif

/* common/rps_pkg.sv */
/*
  Types of the remappable pin select block.
  Assumes rps_params.svh is on the include path.
*/
`include "rps_params.svh"

package rps_pkg;

  typedef logic [`RPS_SEL_W-1:0] rps_sel_t;
  typedef logic [`RPS_REG_W-1:0] rps_reg_t;

  // Whole state of the block, registered as one word
  typedef struct packed {
    logic [`RPS_NUM_PINS-1:0]  pin_meta;
    logic [`RPS_NUM_PINS-1:0]  pin_sync;
    rps_sel_t [`RPS_NUM_IN-1:0]  in_sel;
    rps_sel_t [`RPS_NUM_OUT-1:0] out_sel;
    logic [`RPS_NUM_IN-1:0]    periph_in;
    logic [`RPS_NUM_OUT-1:0]   pin_out;
    logic [`RPS_NUM_OUT-1:0]   pin_en;
    logic                      ack;
    rps_reg_t                  rdata;
  } rps_state_t;

endpackage : rps_pkg

/* src/rps_top.sv */
/*
  Remappable pin select crossbar: routes remappable pins to peripheral
  inputs and peripheral output functions to pins 0 to 5, programmed
  through eight 16-bit selector registers on an Avalon-MM slave.
  Assumes pins are asynchronous, peripheral outputs and the lock level
  come from logic on the same clock.

// Operation
// - Capture channel 8 input follows pin chosen by bits 12..8, reg 0.
// - Capture channel 7 input follows pin chosen by bits 4..0, reg 0.
// - Compare fault A input from bits 4..0; bits 15..5 absent.
// - UART clear-to-send input from pin chosen by bits 12..8.
// - UART receive input from pin chosen by bits 4..0.
// - SPI clock input from pin chosen by bits 12..8.
// - SPI data input from pin chosen by bits 4..0.
// - SPI slave select from bits 4..0 of own register, rest absent.
// - All-ones input code ties the peripheral input low.
// - Input code n selects remappable pin n, 0 to 25.
// - Input selector bits read/write, reset to ones.
// - Output selector bits read/write, reset to zero.
// - Unimplemented bits always read zero.
// - Pin 1 from bits 12..8, pin 0 from bits 4..0, output reg 0.
// - Pin 3 from upper field, pin 2 from lower, output reg 1.
// - Pin 5 from upper field, pin 4 from lower, output reg 2.
// - Selector writes only land while the config lock is clear.
*/
`timescale 1ns/100ps
`include "rps_params.svh"

module rps_top
  import rps_pkg::*;
#(
  parameter int NUM_FUNC = 32
) (
  // Clock, reset, enable
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  // Avalon-MM slave
  input  wire logic [`RPS_ADDR_W-1:0]     avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [`RPS_DATA_W-1:0]     avs_writedata,
  input  wire logic [`RPS_BE_W-1:0]       avs_byteenable,
  output logic [`RPS_DATA_W-1:0]          avs_readdata,
  output logic                            avs_waitrequest,
  // Lock level from the oscillator control logic
  input  wire logic                       remap_config_lock,
  // Remappable pins, asynchronous
  input  wire logic [`RPS_NUM_PINS-1:0]   remappable_pin_n,
  // Peripheral output functions, indexed by function number
  input  wire logic [NUM_FUNC-1:0]        periph_func_out,
  // Pin side of the output crossbar
  output logic [`RPS_NUM_OUT-1:0]         remappable_pin_out,
  output logic [`RPS_NUM_OUT-1:0]         remappable_pin_remap_en,
  // Peripheral inputs
  output logic                            capture_channel_8,
  output logic                            capture_channel_7,
  output logic                            compare_fault_a_input,
  output logic                            uart_clear_to_send_in,
  output logic                            uart_receive_in,
  output logic                            spi_clock_in,
  output logic                            spi_data_in,
  output logic                            spi_slave_select_in
);

  rps_state_t st_ff;
  rps_state_t nxt_st;

  logic bus_req;
  logic bus_done;
  logic wr_commit;

  // Pin lookup; codes above the last pin, ground code included, give low
  function automatic logic pick_pin(
    input rps_sel_t                 sel,
    input logic [`RPS_NUM_PINS-1:0] pins
  );
    logic bit_val;
    bit_val = 1'b0;
    if (sel <= `RPS_MAX_PIN) begin
      bit_val = pins[sel];
    end
    return bit_val;
  endfunction : pick_pin

  // Function number to pin level; zero or unknown numbers connect nothing
  function automatic logic func_valid(input rps_sel_t sel);
    return (sel != `RPS_FUNC_NONE) && (32'(sel) < NUM_FUNC);
  endfunction : func_valid

  function automatic logic pick_func(
    input rps_sel_t            sel,
    input logic [NUM_FUNC-1:0] funcs
  );
    logic bit_val;
    bit_val = 1'b0;
    if (func_valid(sel)) begin
      bit_val = funcs[sel];
    end
    return bit_val;
  endfunction : pick_func

  // Pack two selector fields into a register image, other bits zero
  function automatic rps_reg_t pack_pair(
    input rps_sel_t hi,
    input rps_sel_t lo
  );
    rps_reg_t img;
    img = '0;
    img[`RPS_HI_MSB:`RPS_HI_LSB] = hi;
    img[`RPS_LO_MSB:`RPS_LO_LSB] = lo;
    return img;
  endfunction : pack_pair

  // Register image seen by a read at a word index
  function automatic rps_reg_t read_image(
    input logic [`RPS_ADDR_W-1:0] idx,
    input rps_state_t             s
  );
    rps_reg_t img;
    img = '0;
    unique case (idx)
      `RPS_IDX_CAPTURE: begin
        img = pack_pair(s.in_sel[`RPS_IN_CAP8], s.in_sel[`RPS_IN_CAP7]);
      end
      `RPS_IDX_FAULT: begin
        img = pack_pair(`RPS_OUT_SEL_RST, s.in_sel[`RPS_IN_FAULT]);
      end
      `RPS_IDX_UART: begin
        img = pack_pair(s.in_sel[`RPS_IN_CTS], s.in_sel[`RPS_IN_RX]);
      end
      `RPS_IDX_SPI: begin
        img = pack_pair(s.in_sel[`RPS_IN_SCK], s.in_sel[`RPS_IN_SDI]);
      end
      `RPS_IDX_SPI_SS: begin
        img = pack_pair(`RPS_OUT_SEL_RST, s.in_sel[`RPS_IN_SS]);
      end
      `RPS_IDX_OUT01: begin
        img = pack_pair(s.out_sel[1], s.out_sel[0]);
      end
      `RPS_IDX_OUT23: begin
        img = pack_pair(s.out_sel[3], s.out_sel[2]);
      end
      `RPS_IDX_OUT45: begin
        img = pack_pair(s.out_sel[5], s.out_sel[4]);
      end
      default: begin
        img = '0; // Unmapped words read zero
      end
    endcase
    return img;
  endfunction : read_image

  // Upper field of a write, kept when its byte lane is off
  function automatic rps_sel_t new_hi(
    input rps_sel_t              old,
    input logic [`RPS_DATA_W-1:0] wd,
    input logic [`RPS_BE_W-1:0]   be
  );
    rps_sel_t val;
    val = old;
    if (be[`RPS_HI_BYTE]) begin
      val = wd[`RPS_HI_MSB:`RPS_HI_LSB];
    end
    return val;
  endfunction : new_hi

  // Lower field of a write, kept when its byte lane is off
  function automatic rps_sel_t new_lo(
    input rps_sel_t              old,
    input logic [`RPS_DATA_W-1:0] wd,
    input logic [`RPS_BE_W-1:0]   be
  );
    rps_sel_t val;
    val = old;
    if (be[`RPS_LO_BYTE]) begin
      val = wd[`RPS_LO_MSB:`RPS_LO_LSB];
    end
    return val;
  endfunction : new_lo

  // Every access takes one wait state; the answer edge is the one after
  // the first. Frozen clock holds waitrequest so no edge is lost.
  assign bus_req         = avs_read | avs_write;
  assign bus_done        = st_ff.ack & clk_en;
  assign avs_waitrequest = bus_req & ~bus_done;

  // A locked write is still answered, it just changes nothing
  assign wr_commit = avs_write & bus_done & ~remap_config_lock;

  // Next-state logic for the whole block
  always_comb begin
    nxt_st = st_ff;

    // Two-stage pin synchroniser; only the second stage is looked at
    nxt_st.pin_meta = remappable_pin_n;
    nxt_st.pin_sync = st_ff.pin_meta;

    // Bus handshake: latch read data on the first edge of a request
    if (bus_req && !st_ff.ack) begin
      nxt_st.ack   = 1'b1;
      nxt_st.rdata = read_image(avs_address, st_ff);
    end else begin
      nxt_st.ack   = 1'b0;
    end

    // Selector writes, byte lane by byte lane
    if (wr_commit) begin
      unique case (avs_address)
        `RPS_IDX_CAPTURE: begin
          nxt_st.in_sel[`RPS_IN_CAP8] = new_hi(
            st_ff.in_sel[`RPS_IN_CAP8], avs_writedata, avs_byteenable);
          nxt_st.in_sel[`RPS_IN_CAP7] = new_lo(
            st_ff.in_sel[`RPS_IN_CAP7], avs_writedata, avs_byteenable);
        end
        `RPS_IDX_FAULT: begin
          nxt_st.in_sel[`RPS_IN_FAULT] = new_lo(
            st_ff.in_sel[`RPS_IN_FAULT], avs_writedata, avs_byteenable);
        end
        `RPS_IDX_UART: begin
          nxt_st.in_sel[`RPS_IN_CTS] = new_hi(
            st_ff.in_sel[`RPS_IN_CTS], avs_writedata, avs_byteenable);
          nxt_st.in_sel[`RPS_IN_RX] = new_lo(
            st_ff.in_sel[`RPS_IN_RX], avs_writedata, avs_byteenable);
        end
        `RPS_IDX_SPI: begin
          nxt_st.in_sel[`RPS_IN_SCK] = new_hi(
            st_ff.in_sel[`RPS_IN_SCK], avs_writedata, avs_byteenable);
          nxt_st.in_sel[`RPS_IN_SDI] = new_lo(
            st_ff.in_sel[`RPS_IN_SDI], avs_writedata, avs_byteenable);
        end
        `RPS_IDX_SPI_SS: begin
          nxt_st.in_sel[`RPS_IN_SS] = new_lo(
            st_ff.in_sel[`RPS_IN_SS], avs_writedata, avs_byteenable);
        end
        `RPS_IDX_OUT01: begin
          nxt_st.out_sel[1] = new_hi(
            st_ff.out_sel[1], avs_writedata, avs_byteenable);
          nxt_st.out_sel[0] = new_lo(
            st_ff.out_sel[0], avs_writedata, avs_byteenable);
        end
        `RPS_IDX_OUT23: begin
          nxt_st.out_sel[3] = new_hi(
            st_ff.out_sel[3], avs_writedata, avs_byteenable);
          nxt_st.out_sel[2] = new_lo(
            st_ff.out_sel[2], avs_writedata, avs_byteenable);
        end
        `RPS_IDX_OUT45: begin
          nxt_st.out_sel[5] = new_hi(
            st_ff.out_sel[5], avs_writedata, avs_byteenable);
          nxt_st.out_sel[4] = new_lo(
            st_ff.out_sel[4], avs_writedata, avs_byteenable);
        end
        default: begin
          nxt_st.rdata = st_ff.rdata; // Unmapped writes are dropped
        end
      endcase
    end

    // Input crossbar from the synchronised pins
    nxt_st.periph_in[`RPS_IN_CAP8] =
      pick_pin(st_ff.in_sel[`RPS_IN_CAP8], st_ff.pin_sync);
    nxt_st.periph_in[`RPS_IN_CAP7] =
      pick_pin(st_ff.in_sel[`RPS_IN_CAP7], st_ff.pin_sync);
    nxt_st.periph_in[`RPS_IN_FAULT] =
      pick_pin(st_ff.in_sel[`RPS_IN_FAULT], st_ff.pin_sync);
    nxt_st.periph_in[`RPS_IN_CTS] =
      pick_pin(st_ff.in_sel[`RPS_IN_CTS], st_ff.pin_sync);
    nxt_st.periph_in[`RPS_IN_RX] =
      pick_pin(st_ff.in_sel[`RPS_IN_RX], st_ff.pin_sync);
    nxt_st.periph_in[`RPS_IN_SCK] =
      pick_pin(st_ff.in_sel[`RPS_IN_SCK], st_ff.pin_sync);
    nxt_st.periph_in[`RPS_IN_SDI] =
      pick_pin(st_ff.in_sel[`RPS_IN_SDI], st_ff.pin_sync);
    nxt_st.periph_in[`RPS_IN_SS] =
      pick_pin(st_ff.in_sel[`RPS_IN_SS], st_ff.pin_sync);

    // Output crossbar; pin i follows output selector i
    for (int i = 0; i < `RPS_NUM_OUT; i++) begin
      nxt_st.pin_en[i]  = func_valid(st_ff.out_sel[i]);
      nxt_st.pin_out[i] = pick_func(st_ff.out_sel[i], periph_func_out);
    end
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff.pin_meta  <= '0;
      st_ff.pin_sync  <= '0;
      st_ff.in_sel    <= {`RPS_NUM_IN{`RPS_IN_SEL_RST}};
      st_ff.out_sel   <= {`RPS_NUM_OUT{`RPS_OUT_SEL_RST}};
      st_ff.periph_in <= '0;
      st_ff.pin_out   <= '0;
      st_ff.pin_en    <= '0;
      st_ff.ack       <= 1'b0;
      st_ff.rdata     <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata = {{(`RPS_DATA_W-`RPS_REG_W){1'b0}}, st_ff.rdata};
  assign remappable_pin_out      = st_ff.pin_out;
  assign remappable_pin_remap_en = st_ff.pin_en;
  assign capture_channel_8     = st_ff.periph_in[`RPS_IN_CAP8];
  assign capture_channel_7     = st_ff.periph_in[`RPS_IN_CAP7];
  assign compare_fault_a_input = st_ff.periph_in[`RPS_IN_FAULT];
  assign uart_clear_to_send_in = st_ff.periph_in[`RPS_IN_CTS];
  assign uart_receive_in       = st_ff.periph_in[`RPS_IN_RX];
  assign spi_clock_in          = st_ff.periph_in[`RPS_IN_SCK];
  assign spi_data_in           = st_ff.periph_in[`RPS_IN_SDI];
  assign spi_slave_select_in   = st_ff.periph_in[`RPS_IN_SS];

endmodule : rps_top

/* test/rps_properties.sv */
/*
  Concurrent checks on the pin select crossbar ports, bound into rps_top.
  Assumes one clock domain and the asynchronous active-high reset.
*/
`timescale 1ns/100ps
`include "rps_params.svh"

module rps_properties
  import rps_pkg::*;
#(
  parameter int NUM_FUNC = 32
) (
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  input wire logic                     clk_en,
  // Register bus
  input wire logic [`RPS_ADDR_W-1:0]   avs_address,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [`RPS_DATA_W-1:0]   avs_readdata,
  input wire logic                     avs_waitrequest,
  // Output crossbar
  input wire logic [NUM_FUNC-1:0]      periph_func_out,
  input wire logic [`RPS_NUM_OUT-1:0]  remappable_pin_out,
  input wire logic [`RPS_NUM_OUT-1:0]  remappable_pin_remap_en,
  // Peripheral inputs
  input wire logic                     capture_channel_8,
  input wire logic                     capture_channel_7,
  input wire logic                     compare_fault_a_input,
  input wire logic                     uart_clear_to_send_in,
  input wire logic                     uart_receive_in,
  input wire logic                     spi_clock_in,
  input wire logic                     spi_data_in,
  input wire logic                     spi_slave_select_in
);
  logic       wr_seen_ff;
  logic       rd_done;
  logic [7:0] in_vec;

  // Completed read and the gathered peripheral inputs
  assign rd_done = avs_read && !avs_waitrequest;
  assign in_vec  = {capture_channel_8, capture_channel_7,
                    compare_fault_a_input, uart_clear_to_send_in,
                    uart_receive_in, spi_clock_in, spi_data_in,
                    spi_slave_select_in};

  // Until a write lands, every selector still holds its reset code
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      wr_seen_ff <= 1'b0;
    else if (avs_write && !avs_waitrequest)
      wr_seen_ff <= 1'b1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_wait_one_state: assert property (
    (avs_read || avs_write) && avs_waitrequest && clk_en
    |=> !clk_en || !avs_waitrequest) else $error("wait state too long");
  a_idle_no_wait: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest while idle");
  a_unimpl_zero: assert property (
    rd_done |-> avs_readdata[31:13] == 19'h0 && avs_readdata[7:5] == 3'h0)
    else $error("unimplemented bits set");
  a_single_field: assert property (
    rd_done && (avs_address == 4'h1 || avs_address == 4'h4)
    |-> avs_readdata[15:5] == 11'h0) else $error("upper field present");
  a_en_gates_out: assert property (
    (remappable_pin_out & ~remappable_pin_remap_en) == 6'h00)
    else $error("pin driven without function");
  a_out_follows: assert property (
    $past(clk_en) && (&$past(periph_func_out))
    |-> remappable_pin_out == remappable_pin_remap_en)
    else $error("pin level not from function");
  a_reset_tie_low: assert property (
    !wr_seen_ff |-> in_vec == 8'h00) else $error("input not tied low");
  a_reset_out_off: assert property (
    !wr_seen_ff |-> remappable_pin_remap_en == 6'h00)
    else $error("output function set after reset");
endmodule : rps_properties

bind rps_top rps_properties #(.NUM_FUNC(NUM_FUNC)) rps_properties_i (
  .clock, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .periph_func_out, .remappable_pin_out,
  .remappable_pin_remap_en, .capture_channel_8, .capture_channel_7,
  .compare_fault_a_input, .uart_clear_to_send_in, .uart_receive_in,
  .spi_clock_in, .spi_data_in, .spi_slave_select_in);

/* test/rps_partner.sv */
/*
  Far side stand-in: remappable pin levels and peripheral outputs.
  Assumes the bench steps it through two command words.
*/
`timescale 1ns/100ps
`include "rps_params.svh"

module rps_partner
  import rps_pkg::*;
#(
  parameter int NUM_FUNC = 32
) (
  // Clock and commands
  input  wire logic                     clock,
  input  wire logic [`RPS_NUM_PINS-1:0] pin_cmd,
  input  wire logic [NUM_FUNC-1:0]      func_cmd,
  // Far-side levels
  output logic [`RPS_NUM_PINS-1:0]      pins,
  output logic [NUM_FUNC-1:0]           funcs
);
  // Peripheral logic shares the crossbar clock
  always @(posedge clock) funcs <= func_cmd;
  // Pins move just after a rising edge, like every other bench input
  always @(posedge clock) pins <= pin_cmd;
endmodule : rps_partner

/* test/tb_remappable_pin_select.sv */
/*
  Bench of the pin select crossbar: bus tasks, register images, routing,
  lock and lane checks. Assumes rps_top, its checker and rps_partner.
*/
`timescale 1ns/100ps
`include "rps_params.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("wrong value %s exp %h got %h", n, e, g); end end

module tb_remappable_pin_select
  import rps_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        remap_config_lock = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, periph_func_out, q;
  logic        avs_waitrequest;
  logic [25:0] pin_cmd = 26'h0;
  logic [25:0] remappable_pin_n;
  logic [31:0] func_cmd = 32'h0;
  logic [5:0]  remappable_pin_out, remappable_pin_remap_en, e6;
  wire  [7:0]  pin_in;
  logic [7:0]  e8;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // Pin code per input slot and the writes that set them
  logic [4:0]  sel8 [8] = '{5'h19, 5'h00, 5'h01, 5'h18,
                            5'h02, 5'h03, 5'h04, 5'h05};
  logic [15:0] in_wr [5] = '{16'h1900, 16'h0001, 16'h1802,
                             16'h0304, 16'h0005};
  logic [4:0]  gnd [3] = '{5'h1a, 5'h1e, 5'h1f};
  logic [4:0]  fn6 [6] = '{5'h00, 5'h03, 5'h1f, 5'h07, 5'h10, 5'h01};
  logic [31:0] fpat [3] = '{32'h80010082, 32'h7ffeff7d, 32'hffffffff};

  rps_top rps_top_i (
    .clock, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .remap_config_lock, .remappable_pin_n, .periph_func_out,
    .remappable_pin_out, .remappable_pin_remap_en,
    .capture_channel_8(pin_in[7]), .capture_channel_7(pin_in[6]),
    .compare_fault_a_input(pin_in[5]), .uart_clear_to_send_in(pin_in[4]),
    .uart_receive_in(pin_in[3]), .spi_clock_in(pin_in[2]),
    .spi_data_in(pin_in[1]), .spi_slave_select_in(pin_in[0]));

  rps_partner rps_partner_i (
    .clock, .pin_cmd, .func_cmd, .pins(remappable_pin_n),
    .funcs(periph_func_out));

  // Free-running clock, 4 ns period
  always #2 clock = ~clock;

  // Guard against a hung bus; the whole run needs under 1500 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      end_sim();
    end
  end

  task end_sim;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // One Avalon transfer; waitrequest is read at each rising edge, where
  // it still shows the level the slave presented during the cycle
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) fail_count++;
  endtask : bus

  // Register image after masking to the implemented fields
  function automatic logic [31:0] exp_reg(input int i, input logic [15:0] v);
    if (i == 1 || i == 4) return {16'h0, v & 16'h001f};
    if (i < 8) return {16'h0, v & 16'h1f1f};
    return 32'h0;
  endfunction : exp_reg

  initial begin
    int i, k;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // Reset images, then all ones and all zeros through every lane
    for (i = 0; i < 9; i++) begin
      bus(1'b0, 4'(i), 32'h0, 4'h0);
      `CHK("reset image", exp_reg(i, {16{i < 5}}), q)
    end
    for (k = 0; k < 2; k++)
      for (i = 0; i < 9; i++) begin
        bus(1'b1, 4'(i), k ? 32'h0 : 32'hffffffff, 4'hf);
        bus(1'b0, 4'(i), 32'h0, 4'h0);
        `CHK("readback", exp_reg(i, k ? 16'h0 : 16'hffff), q)
      end
    // Each input slot on its own pin, two opposite pin patterns
    for (i = 0; i < 5; i++)
      bus(1'b1, 4'(i), {16'h0, in_wr[i]}, 4'h3);
    for (k = 0; k < 2; k++) begin
      pin_cmd <= k ? 26'h1555555 : 26'h2aaaaaa;
      repeat (6) @(posedge clock);
      for (i = 0; i < 8; i++)
        e8[7 - i] = pin_cmd[sel8[i]];
      `CHK("inputs", e8, pin_in)
    end
    // Unused and all-ones codes tie inputs low with every pin high
    pin_cmd <= 26'h3ffffff;
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 5; i++)
        bus(1'b1, 4'(i), {19'h0, gnd[k], 3'h0, gnd[k]}, 4'h3);
      repeat (6) @(posedge clock);
      `CHK("tied inputs", 8'h00, pin_in)
    end
    // Output functions per pin, pin 0 left as port I/O
    for (i = 0; i < 3; i++)
      bus(1'b1, 4'(i + 5), {19'h0, fn6[2*i+1], 3'h0, fn6[2*i]}, 4'h3);
    for (k = 0; k < 3; k++) begin
      func_cmd <= fpat[k];
      repeat (3) @(posedge clock);
      for (i = 0; i < 6; i++)
        e6[i] = (fn6[i] != 5'h00) && fpat[k][fn6[i]];
      `CHK("pin levels", e6, remappable_pin_out)
      `CHK("pin enables", 6'h3e, remappable_pin_remap_en)
    end
    // Locked write must leave the selector alone
    remap_config_lock <= 1'b1;
    bus(1'b1, 4'h5, 32'h1f1f, 4'h3);
    bus(1'b0, 4'h5, 32'h0, 4'h0);
    `CHK("locked reg", 32'h0300, q)
    remap_config_lock <= 1'b0;
    // Only the low lane disabled: low field keeps its code
    bus(1'b1, 4'h6, 32'hffff1e1e, 4'he);
    bus(1'b0, 4'h6, 32'h0, 4'h0);
    `CHK("lane gated", 32'h1e1f, q)
    // Frozen clock enable holds the pins, then they catch up
    clk_en <= 1'b0;
    func_cmd <= 32'h0;
    repeat (4) @(posedge clock);
    `CHK("frozen pins", 6'h3e, remappable_pin_out)
    clk_en <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("released pins", 6'h00, remappable_pin_out)
    end_sim();
  end
endmodule : tb_remappable_pin_select
